// ---- logic/cpm_pkg.sv ----
// constants shared by both ends of the control packet buffer
// assumes one clock, pclk, for every register of both ends
`default_nettype none

package cpm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // memories and widths
  localparam int TX_WORDS = 256;
  localparam int TX_WAW = 8;
  localparam int TX_BAW = 10;
  localparam int RX_WORDS = 1024;
  localparam int RX_WAW = 10;
  localparam int RX_BAW = 12;
  localparam int LEN_W = 16;
  localparam int HDR_BYTES = 38;
  localparam int HDR_BITS = 304;
  localparam logic [5:0] HDR_LAST = 6'h25;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int FIFO_CW = 5;

  ////////////////////////////////////////////////////////////////////////////
  // controller register offsets, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX_LEN = 8'h04;
  localparam logic [7:0] REG_TX_ADDR = 8'h08;
  localparam logic [7:0] REG_TX_DATA = 8'h0C;
  localparam logic [7:0] REG_FIFO_COUNT = 8'h10;
  localparam logic [7:0] REG_FIFO_POP = 8'h14;
  localparam logic [7:0] REG_RX_ADDR = 8'h18;
  localparam logic [7:0] REG_RX_DATA = 8'h1C;
  localparam logic [7:0] REG_HDR_BASE = 8'h20;
  localparam logic [7:0] REG_HDR_END = 8'h48;
  localparam logic [7:0] REG_MASK_LO = 8'h48;
  localparam logic [7:0] REG_MASK_HI = 8'h4C;

  ////////////////////////////////////////////////////////////////////////////
  // reset values: ethertype, version, protocol and port filter preset
  localparam logic [319:0] HDR_RESET = {
    32'h0000_1500, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0600_0000, 32'h0000_0000, 32'h0045_0008, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000};
  localparam logic [37:0] MASK_RESET = 38'h33_FC80_7000;

endpackage

`default_nettype wire

// ---- logic/cpm_link_if.sv ----
// link between the packet buffer and its register-side controller
// assumes both ends run on the same pclk
`default_nettype none

interface cpm_link_if;
  logic tx_wr_en;
  logic [cpm_pkg::TX_WAW-1:0] transmit_ram_write_address;
  logic [31:0] tx_wr_data;
  logic [cpm_pkg::LEN_W-1:0] transmit_length;
  logic transmit_request;
  logic transmit_busy_flag;
  logic [cpm_pkg::HDR_BITS-1:0] expected_header_bytes;
  logic [cpm_pkg::HDR_BYTES-1:0] header_byte_enable_mask;
  logic [cpm_pkg::FIFO_CW-1:0] packet_end_fifo_count;
  logic packet_end_fifo_pop;
  logic [cpm_pkg::RX_BAW-1:0] packet_end_fifo_output;
  logic [cpm_pkg::RX_WAW-1:0] receive_ram_word_read_address;
  logic [31:0] receive_ram_word;
  logic commit_end_address_strobe;
  logic header_match_result;

  modport dev (
    input tx_wr_en, transmit_ram_write_address, tx_wr_data, transmit_length,
    input transmit_request, expected_header_bytes, header_byte_enable_mask,
    input packet_end_fifo_pop, receive_ram_word_read_address,
    output transmit_busy_flag, packet_end_fifo_count, packet_end_fifo_output,
    output receive_ram_word, commit_end_address_strobe, header_match_result
  );

  modport ctl (
    output tx_wr_en, transmit_ram_write_address, tx_wr_data, transmit_length,
    output transmit_request, expected_header_bytes, header_byte_enable_mask,
    output packet_end_fifo_pop, receive_ram_word_read_address,
    input transmit_busy_flag, packet_end_fifo_count, packet_end_fifo_output,
    input receive_ram_word, commit_end_address_strobe, header_match_result
  );
endinterface

`default_nettype wire

// ---- logic/cpm_control_packet_mac.sv ----
// control packet buffer: transmit ram to mac stream, mac stream to receive
// ram with header filter and a fifo of committed packet end addresses
// assumes the mac stream is synchronous to pclk and the controller on the link
`default_nettype none

// How it works
// [RULE1] controller starts only when busy reads 0
// [RULE2] packet is written from word address 0
// [RULE3] length set first, then request raised
// [RULE4] busy held, length loaded and counted down
// [RULE5] read pointer reset to 0 at start
// [RULE6] first byte with first marker and valid
// [RULE7] bytes follow back to back after accept
// [RULE8] last marker once remaining count is 2
// [RULE9] busy drops after final byte handed over
// [RULE10] compare window open exactly 38 cycles
// [RULE11] write address reloads from last good end
// [RULE12] every valid byte is written to ram
// [RULE13] bytes 0-37 compared under byte mask
// [RULE14] good packet end pushed and latched
// [RULE15] failing packets not committed, later overwritten
// [RULE16] controller pops fifo then reads ram words
// [RULE17] read port in words, write in bytes
// [RULE18] 32-bit ram port, 8-bit marked stream
// [RULE19] filter preset for ipv4 tcp port 21
// [RULE20] request while busy is ignored
module cpm_control_packet_mac (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller side
  cpm_link_if.dev lk,
  // stream to the mac
  output logic [7:0] mac_out_byte,
  output logic mac_out_first_marker,
  output logic mac_out_valid_strobe,
  output logic mac_out_last_marker,
  input wire logic mac_out_accept,
  // stream from the mac
  input wire logic [7:0] mac_in_byte,
  input wire logic mac_in_first_marker,
  input wire logic mac_in_last_marker,
  input wire logic mac_in_valid_strobe
);

  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} cpm_tx_state_type;

  function automatic logic [7:0] cpm_lane(input logic [31:0] w, input logic [1:0] l);
    cpm_lane = w[{l, 3'b000} +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // transmit ram, written a word at a time
  logic [31:0] tx_ram [cpm_pkg::TX_WORDS];

  always_ff @(posedge pclk)
  begin
    if (lk.tx_wr_en)
      tx_ram[lk.transmit_ram_write_address] <= lk.tx_wr_data; // RULE18
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  cpm_tx_state_type tx_state;
  logic [cpm_pkg::LEN_W-1:0] remaining_length_counter;
  logic [cpm_pkg::TX_BAW-1:0] transmit_ram_read_pointer;
  logic [cpm_pkg::TX_BAW-1:0] next_read_pointer;
  logic [7:0] next_byte;

  // read_pointer_unit: the next byte is fetched while the current one waits
  assign next_read_pointer = transmit_ram_read_pointer + 1'b1;
  assign next_byte = cpm_lane(tx_ram[next_read_pointer[cpm_pkg::TX_BAW-1:2]],
                              next_read_pointer[1:0]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= TX_IDLE;
      lk.transmit_busy_flag <= 1'b0;
      remaining_length_counter <= '0;
      transmit_ram_read_pointer <= '0;
      mac_out_byte <= 8'h00;
      mac_out_valid_strobe <= 1'b0;
      mac_out_first_marker <= 1'b0;
      mac_out_last_marker <= 1'b0;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          // a zero length has nothing to send and is dropped
          if (lk.transmit_request && lk.transmit_length != '0)
          begin
            tx_state <= TX_SEND;
            lk.transmit_busy_flag <= 1'b1; // RULE4
            remaining_length_counter <= lk.transmit_length; // RULE4
            transmit_ram_read_pointer <= '0; // RULE5
            mac_out_byte <= tx_ram[0][7:0]; // RULE5
            mac_out_valid_strobe <= 1'b1; // RULE6
            mac_out_first_marker <= 1'b1; // RULE6
            mac_out_last_marker <= (lk.transmit_length == 16'h0001); // RULE8
          end
        end
        TX_SEND:
        begin
          // requests here fall through untouched
          if (mac_out_valid_strobe && mac_out_accept) // RULE20
          begin
            if (remaining_length_counter == 16'h0001)
            begin
              tx_state <= TX_IDLE;
              lk.transmit_busy_flag <= 1'b0; // RULE9
              remaining_length_counter <= '0;
              mac_out_valid_strobe <= 1'b0;
              mac_out_first_marker <= 1'b0;
              mac_out_last_marker <= 1'b0;
            end
            else
            begin
              remaining_length_counter <= remaining_length_counter - 1'b1; // RULE4
              transmit_ram_read_pointer <= next_read_pointer; // RULE7
              mac_out_byte <= next_byte; // RULE7
              mac_out_first_marker <= 1'b0;
              mac_out_last_marker <= (remaining_length_counter == 16'h0002); // RULE8
            end
          end
        end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive input stage, aligns the byte with the compare window
  logic [7:0] in_byte;
  logic in_valid;
  logic in_first;
  logic in_last;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_byte <= 8'h00;
      in_valid <= 1'b0;
      in_first <= 1'b0;
      in_last <= 1'b0;
    end
    else
    begin
      in_byte <= mac_in_byte;
      in_valid <= mac_in_valid_strobe;
      in_first <= mac_in_first_marker && mac_in_valid_strobe;
      in_last <= mac_in_last_marker;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // header compare window, counted in cycles from the first marker
  logic header_compare_window;
  logic [5:0] header_index;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      header_compare_window <= 1'b0;
      header_index <= 6'h00;
    end
    else if (mac_in_first_marker && mac_in_valid_strobe)
    begin
      header_compare_window <= 1'b1; // RULE10
      header_index <= 6'h00;
    end
    else if (header_compare_window)
    begin
      header_index <= header_index + 1'b1;
      if (header_index == cpm_pkg::HDR_LAST)
        header_compare_window <= 1'b0; // RULE10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // header_matcher
  logic [7:0] expected_byte;
  logic byte_mismatch;
  logic match_so_far;
  logic match_now;

  assign expected_byte = lk.expected_header_bytes[{header_index, 3'b000} +: 8];
  assign byte_mismatch = header_compare_window && in_valid
                         && lk.header_byte_enable_mask[header_index]
                         && (in_byte != expected_byte); // RULE13
  assign match_so_far = in_first ? 1'b1 : lk.header_match_result;
  assign match_now = match_so_far && !byte_mismatch; // RULE13

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lk.header_match_result <= 1'b1;
    else if (in_valid)
      lk.header_match_result <= match_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive ram, bytes in, words out
  logic [31:0] rx_ram [cpm_pkg::RX_WORDS];
  logic [cpm_pkg::RX_BAW-1:0] receive_ram_byte_write_address;
  logic [cpm_pkg::RX_BAW-1:0] last_good_end_latch;
  logic [cpm_pkg::RX_BAW-1:0] byte_address;
  logic fifo_full;
  logic commit;

  assign byte_address = in_first ? last_good_end_latch
                                 : receive_ram_byte_write_address; // RULE11
  // a full fifo refuses the commit, so the packet is dropped, not corrupted
  assign commit = in_valid && in_last && match_now && !fifo_full; // RULE14

  always_ff @(posedge pclk)
  begin
    if (in_valid)
      rx_ram[byte_address[cpm_pkg::RX_BAW-1:2]][{byte_address[1:0], 3'b000} +: 8]
        <= in_byte; // RULE12
    lk.receive_ram_word <= rx_ram[lk.receive_ram_word_read_address]; // RULE17
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_ram_byte_write_address <= '0;
      last_good_end_latch <= '0;
      lk.commit_end_address_strobe <= 1'b0;
    end
    else
    begin
      lk.commit_end_address_strobe <= commit; // RULE14
      if (in_valid)
        receive_ram_byte_write_address <= byte_address + 1'b1; // RULE11
      if (commit)
        last_good_end_latch <= byte_address + 1'b1; // RULE14 RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // packet_end_fifo of committed last byte addresses
  logic [cpm_pkg::RX_BAW-1:0] end_mem [cpm_pkg::FIFO_DEPTH];
  logic [cpm_pkg::FIFO_AW-1:0] fifo_wr;
  logic [cpm_pkg::FIFO_AW-1:0] fifo_rd;
  logic pop;

  assign fifo_full = (lk.packet_end_fifo_count == 5'h10);
  assign pop = lk.packet_end_fifo_pop && (lk.packet_end_fifo_count != '0);

  always_ff @(posedge pclk)
  begin
    if (commit)
      end_mem[fifo_wr] <= byte_address; // RULE14
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fifo_wr <= '0;
      fifo_rd <= '0;
      lk.packet_end_fifo_count <= '0;
      lk.packet_end_fifo_output <= '0;
    end
    else
    begin
      if (commit)
        fifo_wr <= fifo_wr + 1'b1;
      if (pop)
      begin
        fifo_rd <= fifo_rd + 1'b1;
        lk.packet_end_fifo_output <= end_mem[fifo_rd];
      end
      case ({commit, pop})
        2'b10: lk.packet_end_fifo_count <= lk.packet_end_fifo_count + 1'b1;
        2'b01: lk.packet_end_fifo_count <= lk.packet_end_fifo_count - 1'b1;
        default: lk.packet_end_fifo_count <= lk.packet_end_fifo_count;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- logic/cpm_ethernet_register_decoder.sv ----
// apb register block that drives the packet buffer on behalf of firmware
// assumes an apb master on pclk and the buffer on the other side of the link
`default_nettype none

module cpm_ethernet_register_decoder (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // buffer side
  cpm_link_if.ctl lk
);

  logic [319:0] hdr;
  logic [cpm_pkg::TX_WAW-1:0] tx_ptr;
  logic [31:0] rd_mux;
  logic hit;
  logic hdr_hit;
  logic [7:0] hdr_off;
  logic [3:0] hdr_idx;
  logic wr_done;
  logic rd_done;

  assign hdr_off = paddr - cpm_pkg::REG_HDR_BASE;
  assign hdr_idx = hdr_off[5:2];
  assign hdr_hit = (paddr >= cpm_pkg::REG_HDR_BASE) && (paddr < cpm_pkg::REG_HDR_END)
                   && (paddr[1:0] == 2'b00);
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // read mux, sampled in the first access cycle
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      cpm_pkg::REG_CTRL: rd_mux = {30'h0, lk.header_match_result, lk.transmit_busy_flag};
      cpm_pkg::REG_TX_LEN: rd_mux = {16'h0000, lk.transmit_length};
      cpm_pkg::REG_TX_ADDR: rd_mux = {24'h00_0000, tx_ptr};
      cpm_pkg::REG_TX_DATA: rd_mux = 32'h0000_0000;
      cpm_pkg::REG_FIFO_COUNT: rd_mux = {27'h0, lk.packet_end_fifo_count};
      cpm_pkg::REG_FIFO_POP: rd_mux = {20'h0_0000, lk.packet_end_fifo_output};
      cpm_pkg::REG_RX_ADDR: rd_mux = {22'h0, lk.receive_ram_word_read_address};
      cpm_pkg::REG_RX_DATA: rd_mux = lk.receive_ram_word;
      cpm_pkg::REG_MASK_LO: rd_mux = lk.header_byte_enable_mask[31:0];
      cpm_pkg::REG_MASK_HI: rd_mux = {26'h0, lk.header_byte_enable_mask[37:32]};
      default:
      begin
        hit = hdr_hit;
        rd_mux = hdr_hit ? hdr[{hdr_idx, 5'b00000} +: 32] : 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // one wait cycle on every transfer so pointer effects settle first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= !hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and command pulses
  assign lk.expected_header_bytes = hdr[cpm_pkg::HDR_BITS-1:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hdr <= cpm_pkg::HDR_RESET; // RULE19
      lk.header_byte_enable_mask <= cpm_pkg::MASK_RESET; // RULE19
      lk.transmit_length <= '0;
      lk.transmit_request <= 1'b0;
      lk.tx_wr_en <= 1'b0;
      lk.tx_wr_data <= 32'h0000_0000;
      lk.transmit_ram_write_address <= '0;
      lk.packet_end_fifo_pop <= 1'b0;
      lk.receive_ram_word_read_address <= '0;
      tx_ptr <= '0;
    end
    else
    begin
      lk.transmit_request <= 1'b0;
      lk.tx_wr_en <= 1'b0;
      lk.packet_end_fifo_pop <= 1'b0;
      if (wr_done)
      begin
        case (paddr)
          cpm_pkg::REG_CTRL:
            if (pwdata[0])
              lk.transmit_request <= 1'b1; // RULE3
          cpm_pkg::REG_TX_LEN: lk.transmit_length <= pwdata[cpm_pkg::LEN_W-1:0]; // RULE3
          cpm_pkg::REG_TX_ADDR: tx_ptr <= pwdata[cpm_pkg::TX_WAW-1:0]; // RULE2
          cpm_pkg::REG_TX_DATA:
          begin
            lk.tx_wr_en <= 1'b1;
            lk.tx_wr_data <= pwdata;
            lk.transmit_ram_write_address <= tx_ptr; // RULE2
            tx_ptr <= tx_ptr + 1'b1;
          end
          cpm_pkg::REG_FIFO_POP:
            if (lk.packet_end_fifo_count != '0) // RULE16
              lk.packet_end_fifo_pop <= 1'b1;
          cpm_pkg::REG_RX_ADDR:
            lk.receive_ram_word_read_address <= pwdata[cpm_pkg::RX_WAW-1:0];
          cpm_pkg::REG_MASK_LO: lk.header_byte_enable_mask[31:0] <= pwdata; // RULE19
          cpm_pkg::REG_MASK_HI: lk.header_byte_enable_mask[37:32] <= pwdata[5:0];
          default:
            if (hdr_hit)
              hdr[{hdr_idx, 5'b00000} +: 32] <= pwdata; // RULE19
        endcase
      end
      // words are read in order, the word address stepping after each data read
      if (rd_done && paddr == cpm_pkg::REG_RX_DATA)
        lk.receive_ram_word_read_address <= lk.receive_ram_word_read_address + 1'b1; // RULE16
    end
  end

endmodule

`default_nettype wire

// ---- verification/cpm_link_monitor.sv ----
// assertions on the mac streams and link of the packet buffer
// assumes one clock domain and the link joining both design ends
`default_nettype none

module cpm_link_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic transmit_request,
  input wire logic transmit_busy_flag,
  input wire logic commit_end_address_strobe,
  // mac streams
  input wire logic [7:0] mac_out_byte,
  input wire logic mac_out_first_marker,
  input wire logic mac_out_valid_strobe,
  input wire logic mac_out_last_marker,
  input wire logic mac_out_accept,
  input wire logic mac_in_last_marker,
  input wire logic mac_in_valid_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  a_first_has_valid: assert property (mac_out_first_marker |-> mac_out_valid_strobe)
    else $error("first marker without valid");
  a_start_first_byte: assert property ($rose(transmit_busy_flag) |->
    mac_out_valid_strobe && mac_out_first_marker) else $error("send did not open on first byte");
  a_valid_in_busy: assert property (mac_out_valid_strobe |-> transmit_busy_flag)
    else $error("valid outside busy");
  a_stall_holds: assert property (mac_out_valid_strobe && !mac_out_accept |=>
    mac_out_valid_strobe && $stable(mac_out_byte) && $stable(mac_out_first_marker)
    && $stable(mac_out_last_marker)) else $error("byte changed while stalled");
  a_no_gap: assert property (mac_out_valid_strobe && mac_out_accept && !mac_out_last_marker
    |=> mac_out_valid_strobe) else $error("gap inside packet");
  a_last_with_valid: assert property (mac_out_last_marker |-> mac_out_valid_strobe)
    else $error("last marker without valid");
  a_busy_drops: assert property (mac_out_valid_strobe && mac_out_accept && mac_out_last_marker
    |=> !mac_out_valid_strobe && !transmit_busy_flag) else $error("busy held after final byte");
  a_req_while_busy: assert property (transmit_request && transmit_busy_flag
    && !mac_out_first_marker |=> !mac_out_first_marker) else $error("restart while busy");
  a_commit_after_end: assert property (commit_end_address_strobe |->
    $past(mac_in_last_marker && mac_in_valid_strobe, 2)
    || $past(mac_in_last_marker && mac_in_valid_strobe)) else $error("commit without end");
  a_commit_one_cycle: assert property (commit_end_address_strobe |=>
    !commit_end_address_strobe) else $error("commit strobe too long");
endmodule

`default_nettype wire

// ---- verification/tb_control_packet_mac_buffer.sv ----
// self-checking bench: apb master on the decoder, mac stream on the buffer
// assumes both design ends joined by one link on pclk at 50 MHz
`default_nettype none

module tb_control_packet_mac_buffer;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mac_out_accept;
  logic [7:0] paddr, mac_in_byte, mac_out_byte;
  logic [31:0] pwdata, prdata;
  logic mac_out_first_marker, mac_out_valid_strobe, mac_out_last_marker;
  logic mac_in_first_marker, mac_in_last_marker, mac_in_valid_strobe;
  logic [32:0] apq[$];
  logic [32:0] txq[$];
  logic [32:0] ae;
  logic [7:0] rxm [0:4095];
  int endq[$];
  int rx_base = 0;
  int n_commit = 0;
  int bad_count = 0;
  int n_checks = 0;

  cpm_link_if u_cpm_link_if ();
  cpm_control_packet_mac u_cpm_control_packet_mac (.pclk(pclk), .presetn(presetn),
    .lk(u_cpm_link_if), .mac_out_byte(mac_out_byte), .mac_out_accept(mac_out_accept),
    .mac_out_first_marker(mac_out_first_marker), .mac_out_valid_strobe(mac_out_valid_strobe),
    .mac_out_last_marker(mac_out_last_marker), .mac_in_byte(mac_in_byte),
    .mac_in_first_marker(mac_in_first_marker), .mac_in_last_marker(mac_in_last_marker),
    .mac_in_valid_strobe(mac_in_valid_strobe));
  cpm_ethernet_register_decoder u_cpm_ethernet_register_decoder (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lk(u_cpm_link_if));
  cpm_link_monitor u_cpm_link_monitor (.pclk(pclk), .presetn(presetn),
    .transmit_request(u_cpm_link_if.transmit_request),
    .transmit_busy_flag(u_cpm_link_if.transmit_busy_flag),
    .commit_end_address_strobe(u_cpm_link_if.commit_end_address_strobe),
    .mac_out_byte(mac_out_byte), .mac_out_first_marker(mac_out_first_marker),
    .mac_out_valid_strobe(mac_out_valid_strobe), .mac_out_last_marker(mac_out_last_marker),
    .mac_out_accept(mac_out_accept), .mac_in_last_marker(mac_in_last_marker),
    .mac_in_valid_strobe(mac_in_valid_strobe));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // for reads d is the expected word; pslverr is always compared
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    apq.push_back({err, d});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      ae = apq.pop_front();
      check("apb_error", {32'h0, pslverr}, {32'h0, ae[32]});
      if (pwrite === 1'b0)
        check("apb_read", {1'b0, prdata}, {1'b0, ae[31:0]});
    end

  always @(posedge pclk)
    if (presetn === 1'b1 && mac_out_valid_strobe === 1'b1 && mac_out_accept === 1'b1)
    begin
      if (txq.size() == 0)
        check("tx_extra_byte", 33'h1, 33'h0);
      else
        check("tx_byte", {23'h0, mac_out_first_marker, mac_out_last_marker, mac_out_byte},
          txq.pop_front());
    end

  always @(posedge pclk)
    mac_out_accept <= ($urandom_range(3) != 0);

  always @(posedge pclk)
    if (u_cpm_link_if.commit_end_address_strobe === 1'b1)
      n_commit++;

  initial
  begin
    repeat (12000) @(posedge pclk);
    bad_count++;
    $display("watchdog expired");
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tx_test(input int n, input bit again);
    int i;
    logic [31:0] w;
    xfer(1'b0, cpm_pkg::REG_CTRL, 32'h2, 1'b0);
    xfer(1'b1, cpm_pkg::REG_TX_ADDR, 32'h0, 1'b0);
    for (i = 0; i < n; i++)
    begin
      if (i % 4 == 0)
      begin
        w = $urandom;
        xfer(1'b1, cpm_pkg::REG_TX_DATA, w, 1'b0);
      end
      txq.push_back({23'h0, i == 0, i == n - 1, w[8 * (i % 4) +: 8]});
    end
    xfer(1'b1, cpm_pkg::REG_TX_LEN, 32'(n), 1'b0);
    xfer(1'b1, cpm_pkg::REG_CTRL, 32'h1, 1'b0);
    if (again)
      xfer(1'b1, cpm_pkg::REG_CTRL, 32'h1, 1'b0);
    repeat (4) @(posedge pclk);
    i = 0;
    while (u_cpm_link_if.transmit_busy_flag !== 1'b0 && i < 400)
    begin
      @(posedge pclk);
      i++;
    end
    check("tx_drained", 33'(txq.size()), 33'h0);
  endtask

  // header bytes that the preset filter checks, the rest random
  function automatic logic [7:0] hb(input int i);
    if (i == 12)
      return 8'h08;
    if (i == 14)
      return 8'h45;
    if (i == 23)
      return 8'h06;
    if (i == 37)
      return 8'h15;
    if (i == 13 || i == 36 || (i >= 26 && i <= 33))
      return 8'h00;
    return 8'($urandom);
  endfunction

  task automatic send_frame(input int n, input int bi);
    int i;
    logic [7:0] b;
    for (i = 0; i < n; i++)
    begin
      b = hb(i);
      if (i == bi)
        b = b ^ 8'h10;
      rxm[rx_base + i] = b;
      @(posedge pclk);
      mac_in_valid_strobe <= 1'b1;
      mac_in_first_marker <= (i == 0);
      mac_in_last_marker <= (i == n - 1);
      mac_in_byte <= b;
    end
    @(posedge pclk);
    mac_in_valid_strobe <= 1'b0;
    mac_in_first_marker <= 1'b0;
    mac_in_last_marker <= 1'b0;
    mac_in_byte <= ~b;
    if (bi < 0)
    begin
      endq.push_back(rx_base + n - 1);
      rx_base += n;
    end
    repeat (4) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int lens[3] = '{7, 2, 9};
    int bads[5] = '{12, 14, 23, 30, 37};
    void'($urandom(9281));
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mac_out_accept = 1'b0;
    mac_in_byte = 8'h00;
    mac_in_first_marker = 1'b0;
    mac_in_last_marker = 1'b0;
    mac_in_valid_strobe = 1'b0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, cpm_pkg::REG_FIFO_COUNT, 32'h0, 1'b0);
    foreach (lens[i])
      tx_test(lens[i], i == 0);
    $display("test transmit done");
    xfer(1'b0, cpm_pkg::REG_MASK_LO, 32'hFC80_7000, 1'b0);
    xfer(1'b0, cpm_pkg::REG_MASK_HI, 32'h0000_0033, 1'b0);
    xfer(1'b1, 8'h2C, 32'h0045_0008, 1'b0);
    xfer(1'b0, 8'h2C, 32'h0045_0008, 1'b0);
    send_frame(60, -1);
    foreach (bads[i])
      send_frame(45, bads[i]);
    xfer(1'b0, cpm_pkg::REG_CTRL, 32'h0, 1'b0);
    send_frame(41, -1);
    check("commit_count", 33'(n_commit), 33'h2);
    xfer(1'b0, cpm_pkg::REG_FIFO_COUNT, 32'h2, 1'b0);
    foreach (endq[i])
    begin
      xfer(1'b1, cpm_pkg::REG_FIFO_POP, 32'h0, 1'b0);
      xfer(1'b0, cpm_pkg::REG_FIFO_POP, 32'(endq[i]), 1'b0);
    end
    xfer(1'b0, cpm_pkg::REG_FIFO_COUNT, 32'h0, 1'b0);
    xfer(1'b1, cpm_pkg::REG_FIFO_POP, 32'h0, 1'b0);
    xfer(1'b0, cpm_pkg::REG_FIFO_POP, 32'(endq[1]), 1'b0);
    xfer(1'b1, cpm_pkg::REG_RX_ADDR, 32'h0, 1'b0);
    for (int w = 0; w < 26; w++)
      xfer(1'b0, cpm_pkg::REG_RX_DATA, {rxm[4 * w + 3], rxm[4 * w + 2], rxm[4 * w + 1],
        rxm[4 * w]}, 1'b0);
    $display("test receive done");
    xfer(1'b1, 8'h50, 32'h0000_FFFF, 1'b1);
    xfer(1'b0, 8'hFC, 32'h0, 1'b1);
    xfer(1'b0, cpm_pkg::REG_CTRL, 32'h2, 1'b0);
    $display("test map done");
    close_out();
  end
endmodule

`default_nettype wire
